// >>> logic/tps_arbiter.sv
// pin share arbiter: the device end
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - request with grant low asks now
// - request under grant asks next cycle
// - request may rise right after access
// - request held until grant; two-cycle minimum
// - grant on request, held one cycle past drop
// - only granted requester uses shared pins
// - data valid in first granted cycle
// - input part to requester, output part outward
// - optional output enable steers pin drive
// - narrower bus aligned on bit zero, upper zero
// - own request/grant each; shared merged; rest passed
// - everything on one common clock
module tps_arbiter
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // requester ports
  tps_link_if.arbiter lnk0,
  tps_link_if.arbiter lnk1,
  // shared pins
  output tps_pkg::tps_addr_t pin_addr,
  output tps_pkg::tps_data_t pin_data_o,
  output logic pin_data_oe,
  input wire tps_pkg::tps_data_t pin_data_i,
  output logic pin_read,
  output logic pin_write,
  // unshared pins
  output logic pin_chipsel0,
  output logic pin_chipsel1
);
  import tps_pkg::*;

  tps_req_vec_t req;
  tps_req_vec_t grant_q;
  tps_req_vec_t grant_d;
  logic last_q;
  tps_data_t din_s_q;
  tps_data_t din_q;
  logic owner_is1;

  assign req = {lnk1.request, lnk0.request};
  assign lnk0.grant = grant_q[0];
  assign lnk1.grant = grant_q[1];
  assign lnk0.data_in = din_q;
  assign lnk1.data_in = din_q;

  //////////////////////////////////////////////////////////////////////////////
  // grant: stays while request high, drops a cycle after request falls
  always_comb
  begin
    grant_d = grant_q;
    if (grant_q[0] && !req[0])
      grant_d = '0;
    else if (grant_q[1] && !req[1])
      grant_d = '0;
    else if (grant_q == '0)
    begin
      // round robin: favour the one that did not own last
      if (req[0] && req[1])
        grant_d = last_q ? 2'h1 : 2'h2;
      else
        grant_d = req;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      grant_q <= '0;
    else
      grant_q <= grant_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      last_q <= 1'b1;
    else if (grant_d != '0)
      last_q <= grant_d[1];
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared pin mux, registered; enable follows grant_d so pins act in cycle of grant
  assign owner_is1 = grant_d[1];

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || grant_d == '0)
    begin
      pin_addr <= '0;
      pin_data_o <= '0;
      pin_data_oe <= 1'b0;
      pin_read <= 1'b0;
      pin_write <= 1'b0;
    end
    else if (owner_is1)
    begin
      // requester 1 has a narrow address
      pin_addr <= {{(`TPS_ADDR_W-`TPS_NARROW_ADDR_W){1'b0}},
        lnk1.addr_out[`TPS_NARROW_ADDR_W-1:0]};
      pin_data_o <= lnk1.data_out;
      pin_data_oe <= lnk1.data_outen;
      pin_read <= lnk1.read_out;
      pin_write <= lnk1.write_out;
    end
    else
    begin
      pin_addr <= lnk0.addr_out;
      pin_data_o <= lnk0.data_out;
      pin_data_oe <= lnk0.data_outen;
      pin_read <= lnk0.read_out;
      pin_write <= lnk0.write_out;
    end
  end

  // pin input passes two stages before the requesters see it
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      din_s_q <= '0;
      din_q <= '0;
    end
    else
    begin
      din_s_q <= pin_data_i;
      din_q <= din_s_q;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pin_chipsel0 <= 1'b0;
      pin_chipsel1 <= 1'b0;
    end
    else
    begin
      pin_chipsel0 <= lnk0.chipsel_out;
      pin_chipsel1 <= lnk1.chipsel_out;
    end
  end
endmodule // tps_arbiter

// >>> logic/tps_consts.svh
// constants of the tristate pin share arbiter
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH
`define TPS_NUM_REQ 2
`define TPS_ADDR_W 16
`define TPS_DATA_W 16
`define TPS_NARROW_ADDR_W 12
`define TPS_GRANT_HOLD_CYC 1
`define TPS_MIN_ACCESS_CYC 2
`endif

// >>> logic/tps_pkg.sv
// types of the tristate pin share arbiter
`include "tps_consts.svh"
package tps_pkg;
  typedef logic [`TPS_NUM_REQ-1:0] tps_req_vec_t;
  typedef logic [`TPS_ADDR_W-1:0] tps_addr_t;
  typedef logic [`TPS_DATA_W-1:0] tps_data_t;
  typedef enum logic [1:0]
  {
    TPS_REQ_IDLE = 2'h0,
    TPS_REQ_WAIT = 2'h1,
    TPS_REQ_OWN = 2'h3
  } tps_req_state_t;
endpackage

// >>> logic/tps_link_if.sv
// conduit between one requester and the arbiter
`timescale 1ns/100ps
interface tps_link_if;
  import tps_pkg::*;
  logic request;
  logic grant;
  tps_addr_t addr_out;
  tps_data_t data_out;
  logic data_outen;
  logic read_out;
  logic write_out;
  tps_data_t data_in;
  logic chipsel_out;
  modport requester
  (
    output request, addr_out, data_out, data_outen, read_out, write_out, chipsel_out,
    input grant, data_in
  );
  modport arbiter
  (
    input request, addr_out, data_out, data_outen, read_out, write_out, chipsel_out,
    output grant, data_in
  );
endinterface

// >>> logic/tps_requester.sv
// pin bus requester: the far end
`timescale 1ns/100ps
module tps_requester
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // user command: len beats of access, at least two
  input wire logic usr_go,
  input wire logic [3:0] usr_len,
  input wire logic usr_wr,
  input wire tps_pkg::tps_addr_t usr_addr,
  input wire tps_pkg::tps_data_t usr_wdata,
  output logic usr_busy,
  output tps_pkg::tps_data_t usr_rdata,
  // link to arbiter
  tps_link_if.requester lnk
);
  import tps_pkg::*;

  tps_req_state_t st_q;
  logic [3:0] left_q;
  logic wr_q;
  tps_addr_t addr_q;
  tps_data_t wdata_q;
  logic req_q;

  assign lnk.request = req_q;
  assign lnk.addr_out = addr_q;
  assign lnk.data_out = wdata_q;
  // command shown while requesting; the registered pin mux lands it in the granted cycles
  assign lnk.data_outen = req_q && wr_q;
  assign lnk.read_out = req_q && !wr_q;
  assign lnk.write_out = req_q && wr_q;
  assign lnk.chipsel_out = st_q != TPS_REQ_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      st_q <= TPS_REQ_IDLE;
      req_q <= 1'b0;
      left_q <= '0;
      wr_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end
    else
    begin
      unique case (st_q)
        TPS_REQ_IDLE:
          if (usr_go)
          begin
            st_q <= TPS_REQ_WAIT;
            req_q <= 1'b1;
            left_q <= (usr_len < 4'h2) ? 4'h2 : usr_len;
            wr_q <= usr_wr;
            addr_q <= usr_addr;
            wdata_q <= usr_wdata;
          end
        TPS_REQ_WAIT:
          if (lnk.grant)
          begin
            st_q <= TPS_REQ_OWN;
            left_q <= left_q - 4'h1;
            if (left_q == 4'h2)
              req_q <= 1'b0;
          end
        TPS_REQ_OWN:
        begin
          left_q <= left_q - 4'h1;
          if (left_q == 4'h2)
            req_q <= 1'b0;
          if (left_q == 4'h1)
            st_q <= TPS_REQ_IDLE;
        end
        default:
          st_q <= TPS_REQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      usr_busy <= 1'b0;
    else
      usr_busy <= (st_q != TPS_REQ_IDLE) || usr_go;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      usr_rdata <= '0;
    else if (st_q == TPS_REQ_OWN && !wr_q)
      usr_rdata <= lnk.data_in;
  end
endmodule // tps_requester

// >>> verification/tps_arb_assertions.sv
// assertions on the two links and the shared pins
`timescale 1ns/100ps
`include "tps_consts.svh"
module tps_arb_assertions
  import tps_pkg::*;
(
  // clock and reset
  input logic sys_clk,
  input logic rst_b,
  // links
  input logic request0,
  input logic grant0,
  input logic request1,
  input logic grant1,
  input tps_addr_t addr_out0,
  input logic chipsel_out0,
  // shared pins, and the unshared pin_chipsel0
  input tps_addr_t pin_addr,
  input logic pin_data_oe,
  input logic pin_chipsel0
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_drop0;
    grant0 && !request0;
  endsequence
  sequence s_pass0;
    $fell(grant0) ##0 request1;
  endsequence
  property p_one; !(grant0 && grant1); endproperty
  a_one: assert property (p_one) else $error("two grants at once");
  property p_rise0; $rose(grant0) |-> $past(request0); endproperty
  a_rise0: assert property (p_rise0) else $error("grant without request");
  property p_hold0; grant0 && request0 |=> grant0; endproperty
  a_hold0: assert property (p_hold0) else $error("grant dropped early");
  property p_drop0; s_drop0 |=> !grant0; endproperty
  a_drop0: assert property (p_drop0) else $error("grant held too long");
  property p_pass0; s_pass0 |-> ##[1:3] grant1; endproperty
  a_pass0: assert property (p_pass0) else $error("waiting requester skipped");
  property p_idle; !grant0 && !grant1 |-> !pin_data_oe; endproperty
  a_idle: assert property (p_idle) else $error("enable high while idle");
  property p_narrow; grant1 |-> (pin_addr >> `TPS_NARROW_ADDR_W) == '0; endproperty
  a_narrow: assert property (p_narrow) else $error("upper pins not zero");
  property p_addr0; grant0 |-> pin_addr == $past(addr_out0); endproperty
  a_addr0: assert property (p_addr0) else $error("owner address not on pins");
  property p_cs0; pin_chipsel0 == $past(chipsel_out0); endproperty
  a_cs0: assert property (p_cs0) else $error("unshared pin not passed");
endmodule // tps_arb_assertions

// >>> verification/tristate_pin_share_arbiter_tb.sv
// bench for both ends of the pin share arbiter
`timescale 1ns/100ps
module tristate_pin_share_arbiter_tb;
  import tps_pkg::*;
  logic sys_clk = 0;
  logic rst_b = 0;
  logic [1:0] done = 0;
  tps_data_t pin_data_i = 16'h5a3c;
  tps_addr_t pin_addr;
  tps_data_t pin_data_o;
  logic pin_data_oe, pin_read, pin_write;
  logic pin_cs0, pin_cs1;
  int err_total = 0;
  int checks = 0;
  tps_link_if l [2] ();
  task automatic cmp(string nm, logic [34:0] seen, logic [34:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  tps_arbiter u_tps_arbiter (.sys_clk(sys_clk), .rst_b(rst_b), .lnk0(l[0].arbiter),
    .lnk1(l[1].arbiter), .pin_addr(pin_addr), .pin_data_o(pin_data_o),
    .pin_data_oe(pin_data_oe), .pin_data_i(pin_data_i), .pin_read(pin_read),
    .pin_write(pin_write), .pin_chipsel0(pin_cs0), .pin_chipsel1(pin_cs1));
  tps_arb_assertions u_tps_arb_assertions (.sys_clk(sys_clk), .rst_b(rst_b),
    .request0(l[0].request), .grant0(l[0].grant), .request1(l[1].request),
    .grant1(l[1].grant), .addr_out0(l[0].addr_out), .chipsel_out0(l[0].chipsel_out),
    .pin_addr(pin_addr), .pin_data_oe(pin_data_oe),
    .pin_chipsel0(pin_cs0));
  //////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < 2; i++)
  begin : g
    logic go = 0;
    logic w = 0;
    logic gp = 0;
    logic [3:0] ln = 4'h2;
    tps_addr_t a = 16'h0;
    tps_data_t d = 16'h0;
    logic busy;
    tps_data_t rd;
    logic [34:0] q [$];
    logic [34:0] pins_now;
    int seed = 24;
    tps_requester u_tps_requester (.sys_clk(sys_clk), .rst_b(rst_b), .usr_go(go),
      .usr_len(ln), .usr_wr(w), .usr_addr(a), .usr_wdata(d), .usr_busy(busy),
      .usr_rdata(rd), .lnk(l[i].requester));
    assign pins_now = {pin_addr, pin_data_oe, pin_read, pin_write, pin_data_o & {16{pin_write}}};
    initial
    begin
      repeat (13) @(posedge sys_clk);
      for (int t = 0; t < 16; t++)
      begin
        go <= 1'b1;
        ln <= 4'h2 + 4'($unsigned($random(seed)) % 14);
        a <= 16'($random(seed));
        d <= 16'($random(seed));
        w <= 1'($random(seed));
        @(posedge sys_clk);
        go <= 1'b0;
        q.push_back({(i == 1) ? a & 16'h0fff : a, w, !w, w, w ? d : 16'h0});
        // busy rises at the same edge that takes go; skip one more edge before polling it
        @(posedge sys_clk);
        for (int n = 0; n < 200 && busy !== 1'b0; n++)
          @(posedge sys_clk);
        if (busy !== 1'b0)
        begin
          err_total++;
          break;
        end
        if (w === 1'b0)
          cmp("rdata", 35'(rd), 35'(pin_data_i));
      end
      done[i] = 1'b1;
    end
    // first granted cycle carries the whole command
    always @(posedge sys_clk)
    begin
      gp <= l[i].grant;
      if (l[i].grant === 1'b1 && gp === 1'b0)
      begin
        cmp("pins", pins_now, q.size() ? q.pop_front() : 35'h0);
        cmp("chipsel", 35'((i == 0) ? pin_cs0 : pin_cs1), 35'h1);
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int n = 0; n < 20000 && done !== 2'b11; n++)
      @(posedge sys_clk);
    if (done !== 2'b11)
      err_total++;
    report_and_stop;
  end
endmodule // tristate_pin_share_arbiter_tb
